// *** inc/fdrp_defines.vh ***
`ifndef FDRP_DEFINES_VH
`define FDRP_DEFINES_VH

`define FDRP_CLK_MHZ 125
`define FDRP_WIN_US 10000
`define FDRP_US_PER_S 1000000

`define FDRP_A_OUTSEL 8'h00
`define FDRP_A_DET 8'h04
`define FDRP_A_BRAKE 8'h08
`define FDRP_A_TYPE 8'h0C
`define FDRP_A_UPDN 8'h10
`define FDRP_A_PCFG 8'h14
`define FDRP_A_PSCALE 8'h18
`define FDRP_A_PGB 8'h1C
`define FDRP_A_PFILT 8'h20
`define FDRP_A_STAT 8'h24
`define FDRP_A_PFREQ 8'h28
`define FDRP_A_PPCT 8'h2C
`define FDRP_A_IRQS 8'h30
`define FDRP_A_IRQM 8'h34
`define FDRP_A_UDREF 8'h38

`define FDRP_F_R1FN 0
`define FDRP_F_R2FN 8
`define FDRP_F_PHFN 16
`define FDRP_F_HI 16
`define FDRP_F_R1NC 0
`define FDRP_F_R2NC 1
`define FDRP_F_PHNC 8
`define FDRP_F_PFN 0
`define FDRP_F_RSRC 4
`define FDRP_F_FBSRC 8

`define FDRP_FN_AGREE 5'h03
`define FDRP_FN_FDET1 5'h04
`define FDRP_FN_FDET2 5'h05
`define FDRP_FN_BRAKE 5'h0E
`define FDRP_UD_HOLD 2'h0
`define FDRP_UD_CLEAR 2'h1
`define FDRP_UD_FREE 2'h2
`define FDRP_PF_FREQ 2'h0
`define FDRP_PF_PIDFB 2'h1
`define FDRP_PF_PIDTG 2'h2
`define FDRP_SRC_PULSE 3'h4
`define FDRP_FB_PULSE 3'h3

`define FDRP_RST_PSCALE 16'h2710
`define FDRP_RST_PGAIN 14'h03E8
`define FDRP_PCT_FULL 40'h00_0000_03E8
`define FDRP_UD_STEP 16'h0001
`define FDRP_UD_MAX 16'hFFFF

`define FDRP_EV_SERR 0
`define FDRP_EV_BRAKE 1
`define FDRP_EV_SAMP 2

`endif

// *** hdl/fdrp_pulse_meas.v ***
`include "fdrp_defines.vh"

module fdrp_pulse_meas #(
    parameter WIN_CYC = 1250000
) (
    input wire i_clk_sys,
    input wire i_nrst,
    input wire i_pin,
    output reg [15:0] o_count,
    output reg o_done
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    reg lvl_r;
    reg [31:0] win_r;
    reg [15:0] cnt_r;
    wire agree;
    wire rise;
    wire win_end;

    // Level accepted only once stages two and three agree
    assign agree = (s2_r == s3_r);
    assign rise = agree & s2_r & ~lvl_r;
    assign win_end = (win_r == WIN_CYC - 1);

    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            lvl_r <= 1'b0;
            win_r <= 32'h0000_0000;
            cnt_r <= 16'h0000;
            o_count <= 16'h0000;
            o_done <= 1'b0;
        end else begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (agree) begin
                lvl_r <= s2_r;
            end
            o_done <= win_end;
            if (win_end) begin
                win_r <= 32'h0000_0000;
                o_count <= cnt_r;
                cnt_r <= {15'h0000, rise};
            end else begin
                win_r <= win_r + 32'h0000_0001;
                if (rise && cnt_r != 16'hFFFF) begin
                    cnt_r <= cnt_r + 16'h0001;
                end
            end
        end
    end
endmodule

// *** hdl/fdrp_top.v ***
// Operation
// - Code 4: on above level+width, off below level
// - Code 5: on within level to level+width
// - Code 14: brake relay by release/operation levels
// - Relay type bits: 0 open, 1 closed
// - Retention 0: keep reference over stop
// - Retention 1: clear reference on stop
// - Retention 2: adjust reference while stopped
// - Photo output shares functions, own polarity bit
// - Pulse function routes input: freq, feedback, target
// - Scale frequency equals one hundred percent
// - Percent is normalised times gain plus bias
// - Pulse frequency smoothed by filter time
// - Frequency command when source 4, function 0
// - PID feedback when source 4, function 1, fb 3
// - Setting error: function 1, feedback source not 3
// - Code 3: on when output within width of reference
`include "fdrp_defines.vh"

module fdrp_top #(
    parameter WIN_CYC = `FDRP_WIN_US * `FDRP_CLK_MHZ
) (
    input wire i_clk_sys,
    input wire i_nrst,
    input wire [7:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    input wire [15:0] i_out_freq,
    input wire [15:0] i_freq_ref,
    input wire i_accel,
    input wire i_decel,
    input wire i_run,
    input wire i_up,
    input wire i_down,
    input wire i_pulse_train_input,
    output reg o_first_relay,
    output reg o_second_relay,
    output reg o_photo_out,
    output reg [15:0] o_updn_ref,
    output reg signed [31:0] o_pulse_pct,
    output reg o_use_freq_cmd,
    output reg o_use_pid_fb,
    output reg o_use_pid_tgt,
    output reg o_pulse_setting_error,
    output reg o_irq
);
    reg [4:0] fn_r1_r;
    reg [4:0] fn_r2_r;
    reg [4:0] fn_ph_r;
    reg [15:0] det_lvl_r;
    reg [15:0] det_wid_r;
    reg [15:0] rel_lvl_r;
    reg [15:0] op_lvl_r;
    reg [1:0] rtype_r;
    reg ptype_r;
    reg [1:0] ud_mode_r;
    reg [1:0] pfn_r;
    reg [2:0] rsrc_r;
    reg [2:0] fbsrc_r;
    reg [15:0] pscale_r;
    reg [13:0] pgain_r;
    reg signed [15:0] pbias_r;
    reg [7:0] pfilt_r;
    reg [2:0] irq_st_r;
    reg [2:0] irq_mk_r;
    reg fdet1_r;
    reg brake_r;
    reg run_d_r;
    reg serr_d_r;
    reg [31:0] filt_r;
    reg [31:0] pbase_r;
    reg st1_r;
    reg st2_r;
    reg [2:0] ev_nxt;
    reg [15:0] ud_nxt;
    reg [31:0] filt_nxt;
    reg [39:0] fstep_nxt;
    reg [31:0] rd_nxt;
    wire [15:0] pcount;
    wire pdone;
    wire [16:0] lvl_hi;
    wire [15:0] fdiff;
    wire fdet2;
    wire agree;
    wire serr;
    wire [31:0] raw_hz;
    wire [31:0] filt_hz;
    wire [39:0] gained;
    wire [39:0] pbase_q;
    wire [39:0] pct_q;

    fdrp_pulse_meas #(
        .WIN_CYC(WIN_CYC)
    ) u_meas (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_pin(i_pulse_train_input),
        .o_count(pcount),
        .o_done(pdone)
    );

    function [39:0] udiv;
        input [39:0] num;
        input [39:0] den;
        begin
            // Zero divisor guarded; scale never legally below 50
            if (den == 40'h00_0000_0000) begin
                udiv = num;
            end else begin
                udiv = num / den;
            end
        end
    endfunction

    function sel_out;
        input [4:0] code;
        input agree_f;
        input det1_f;
        input det2_f;
        input brk_f;
        begin
            case (code)
                `FDRP_FN_AGREE: sel_out = agree_f;
                `FDRP_FN_FDET1: sel_out = det1_f;
                `FDRP_FN_FDET2: sel_out = det2_f;
                `FDRP_FN_BRAKE: sel_out = brk_f;
                default: sel_out = 1'b0;
            endcase
        end
    endfunction

    assign lvl_hi = {1'b0, det_lvl_r} + {1'b0, det_wid_r};
    assign fdiff = (i_out_freq >= i_freq_ref) ?
        i_out_freq - i_freq_ref : i_freq_ref - i_out_freq;
    assign agree = (fdiff <= det_wid_r);
    assign fdet2 = ({1'b0, i_out_freq} < lvl_hi) &&
        (i_out_freq >= det_lvl_r);
    assign serr = (pfn_r == `FDRP_PF_PIDFB) &&
        (fbsrc_r != `FDRP_FB_PULSE);
    // Window count to Hz: windows per second is exact
    assign raw_hz = {16'h0000, pcount} *
        (`FDRP_US_PER_S / `FDRP_WIN_US);
    assign filt_hz = {8'h00, filt_r[31:8]};
    assign gained = pbase_r[25:0] * pgain_r;
    assign pbase_q = udiv({16'h0000, filt_hz[23:0]} * `FDRP_PCT_FULL,
        {24'h00_0000, pscale_r});
    assign pct_q = udiv(gained, `FDRP_PCT_FULL);

    // One smoothing step per window: step = error / (tau + 1)
    always @* begin
        // Fraction bits join the compare so the step never wraps
        if ({raw_hz[23:0], 8'h00} >= filt_r) begin
            fstep_nxt = udiv({8'h00, raw_hz[23:0], 8'h00} -
                {8'h00, filt_r}, {32'h0000_0000, pfilt_r} +
                40'h00_0000_0001);
            filt_nxt = filt_r + fstep_nxt[31:0];
        end else begin
            fstep_nxt = udiv({8'h00, filt_r} -
                {8'h00, raw_hz[23:0], 8'h00},
                {32'h0000_0000, pfilt_r} + 40'h00_0000_0001);
            filt_nxt = filt_r - fstep_nxt[31:0];
        end
    end

    always @* begin
        ud_nxt = o_updn_ref;
        if (run_d_r && !i_run) begin
            if (ud_mode_r == `FDRP_UD_CLEAR) begin
                ud_nxt = 16'h0000;
            end
        end else if (i_run || ud_mode_r == `FDRP_UD_FREE) begin
            if (i_up && !i_down && o_updn_ref != `FDRP_UD_MAX) begin
                ud_nxt = o_updn_ref + `FDRP_UD_STEP;
            end else if (i_down && !i_up &&
                o_updn_ref != 16'h0000) begin
                ud_nxt = o_updn_ref - `FDRP_UD_STEP;
            end
        end
        // Mode 0 leaves the value untouched across the stop
    end

    always @* begin
        ev_nxt = 3'h0;
        ev_nxt[`FDRP_EV_SERR] = serr & ~serr_d_r;
        ev_nxt[`FDRP_EV_BRAKE] = st1_r;
        ev_nxt[`FDRP_EV_SAMP] = st2_r;
    end

    always @* begin
        case (i_addr)
            `FDRP_A_OUTSEL: rd_nxt = {11'h000, fn_ph_r, 3'h0, fn_r2_r,
                3'h0, fn_r1_r};
            `FDRP_A_DET: rd_nxt = {det_wid_r, det_lvl_r};
            `FDRP_A_BRAKE: rd_nxt = {op_lvl_r, rel_lvl_r};
            `FDRP_A_TYPE: rd_nxt = {23'h00_0000, ptype_r, 6'h00,
                rtype_r};
            `FDRP_A_UPDN: rd_nxt = {30'h0000_0000, ud_mode_r};
            `FDRP_A_PCFG: rd_nxt = {21'h00_0000, fbsrc_r, 1'b0,
                rsrc_r, 2'h0, pfn_r};
            `FDRP_A_PSCALE: rd_nxt = {16'h0000, pscale_r};
            `FDRP_A_PGB: rd_nxt = {pbias_r, 2'h0, pgain_r};
            `FDRP_A_PFILT: rd_nxt = {24'h00_0000, pfilt_r};
            `FDRP_A_STAT: rd_nxt = {26'h000_0000, o_pulse_setting_error,
                brake_r, fdet1_r, o_photo_out, o_second_relay,
                o_first_relay};
            `FDRP_A_PFREQ: rd_nxt = filt_hz;
            `FDRP_A_PPCT: rd_nxt = o_pulse_pct;
            `FDRP_A_IRQS: rd_nxt = {29'h0000_0000, irq_st_r};
            `FDRP_A_IRQM: rd_nxt = {29'h0000_0000, irq_mk_r};
            `FDRP_A_UDREF: rd_nxt = {16'h0000, o_updn_ref};
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            fn_r1_r <= 5'h00;
            fn_r2_r <= 5'h00;
            fn_ph_r <= 5'h00;
            det_lvl_r <= 16'h0000;
            det_wid_r <= 16'h0000;
            rel_lvl_r <= 16'h0000;
            op_lvl_r <= 16'h0000;
            rtype_r <= 2'h0;
            ptype_r <= 1'b0;
            ud_mode_r <= 2'h0;
            pfn_r <= 2'h0;
            rsrc_r <= 3'h0;
            fbsrc_r <= 3'h0;
            pscale_r <= `FDRP_RST_PSCALE;
            pgain_r <= `FDRP_RST_PGAIN;
            pbias_r <= 16'h0000;
            pfilt_r <= 8'h00;
            irq_mk_r <= 3'h0;
        end else if (i_wr) begin
            case (i_addr)
                `FDRP_A_OUTSEL: begin
                    fn_r1_r <= i_wdata[`FDRP_F_R1FN +: 5];
                    fn_r2_r <= i_wdata[`FDRP_F_R2FN +: 5];
                    fn_ph_r <= i_wdata[`FDRP_F_PHFN +: 5];
                end
                `FDRP_A_DET: begin
                    det_lvl_r <= i_wdata[15:0];
                    det_wid_r <= i_wdata[31:16];
                end
                `FDRP_A_BRAKE: begin
                    rel_lvl_r <= i_wdata[15:0];
                    op_lvl_r <= i_wdata[31:16];
                end
                `FDRP_A_TYPE: begin
                    rtype_r[0] <= i_wdata[`FDRP_F_R1NC];
                    rtype_r[1] <= i_wdata[`FDRP_F_R2NC];
                    ptype_r <= i_wdata[`FDRP_F_PHNC];
                end
                `FDRP_A_UPDN: ud_mode_r <= i_wdata[1:0];
                `FDRP_A_PCFG: begin
                    pfn_r <= i_wdata[`FDRP_F_PFN +: 2];
                    rsrc_r <= i_wdata[`FDRP_F_RSRC +: 3];
                    fbsrc_r <= i_wdata[`FDRP_F_FBSRC +: 3];
                end
                `FDRP_A_PSCALE: pscale_r <= i_wdata[15:0];
                `FDRP_A_PGB: begin
                    pgain_r <= i_wdata[13:0];
                    pbias_r <= i_wdata[31:16];
                end
                `FDRP_A_PFILT: pfilt_r <= i_wdata[7:0];
                `FDRP_A_IRQM: irq_mk_r <= i_wdata[2:0];
                default: pfilt_r <= pfilt_r;
            endcase
        end
    end

    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            fdet1_r <= 1'b0;
            brake_r <= 1'b0;
            run_d_r <= 1'b0;
            serr_d_r <= 1'b0;
            o_updn_ref <= 16'h0000;
            o_first_relay <= 1'b0;
            o_second_relay <= 1'b0;
            o_photo_out <= 1'b0;
            o_pulse_setting_error <= 1'b0;
            o_use_freq_cmd <= 1'b0;
            o_use_pid_fb <= 1'b0;
            o_use_pid_tgt <= 1'b0;
            st1_r <= 1'b0;
        end else begin
            if ({1'b0, i_out_freq} > lvl_hi) begin
                fdet1_r <= 1'b1;
            end else if (i_out_freq < det_lvl_r) begin
                fdet1_r <= 1'b0;
            end
            st1_r <= 1'b0;
            if (i_accel && !brake_r && i_out_freq >= rel_lvl_r) begin
                brake_r <= 1'b1;
                st1_r <= 1'b1;
            end else if (i_decel && brake_r &&
                i_out_freq <= op_lvl_r) begin
                brake_r <= 1'b0;
                st1_r <= 1'b1;
            end
            run_d_r <= i_run;
            o_updn_ref <= ud_nxt;
            o_first_relay <= rtype_r[0] ^ sel_out(fn_r1_r, agree,
                fdet1_r, fdet2, brake_r);
            o_second_relay <= rtype_r[1] ^ sel_out(fn_r2_r, agree,
                fdet1_r, fdet2, brake_r);
            o_photo_out <= ptype_r ^ sel_out(fn_ph_r, agree,
                fdet1_r, fdet2, brake_r);
            serr_d_r <= serr;
            o_pulse_setting_error <= serr;
            o_use_freq_cmd <= (rsrc_r == `FDRP_SRC_PULSE) &&
                (pfn_r == `FDRP_PF_FREQ);
            o_use_pid_fb <= (rsrc_r == `FDRP_SRC_PULSE) &&
                (pfn_r == `FDRP_PF_PIDFB) &&
                (fbsrc_r == `FDRP_FB_PULSE);
            o_use_pid_tgt <= (rsrc_r == `FDRP_SRC_PULSE) &&
                (pfn_r == `FDRP_PF_PIDTG);
        end
    end

    // Three-stage arithmetic keeps each divider on its own cycle
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            filt_r <= 32'h0000_0000;
            pbase_r <= 32'h0000_0000;
            o_pulse_pct <= 32'h0000_0000;
            st2_r <= 1'b0;
        end else begin
            if (pdone) begin
                filt_r <= filt_nxt;
            end
            pbase_r <= pbase_q[31:0];
            o_pulse_pct <= $signed({1'b0, pct_q[30:0]}) + pbias_r;
            st2_r <= pdone;
        end
    end

    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_st_r <= 3'h0;
            o_irq <= 1'b0;
            o_rdata <= 32'h0000_0000;
        end else begin
            // Set beats a same-cycle write-one clear
            if (i_wr && i_addr == `FDRP_A_IRQS) begin
                irq_st_r <= (irq_st_r & ~i_wdata[2:0]) | ev_nxt;
            end else begin
                irq_st_r <= irq_st_r | ev_nxt;
            end
            o_irq <= |(irq_st_r & irq_mk_r);
            o_rdata <= i_rd ? rd_nxt : 32'h0000_0000;
        end
    end
endmodule

// *** test/fdrp_chk_sva.sv ***
`include "fdrp_defines.vh"

module fdrp_chk #(
    parameter WIN_CYC = 1000
) (
    input wire i_clk_sys,
    input wire i_nrst,
    input wire [7:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [31:0] o_rdata,
    input wire [15:0] i_out_freq,
    input wire [15:0] i_freq_ref,
    input wire i_accel,
    input wire i_run,
    input wire i_up,
    input wire i_down,
    input wire o_first_relay,
    input wire o_second_relay,
    input wire o_photo_out,
    input wire [15:0] o_updn_ref,
    input wire o_use_freq_cmd,
    input wire o_use_pid_fb,
    input wire o_pulse_setting_error
);
    reg [31:0] sel_r, det_r, brk_r, typ_r, ud_r, pc_r;
    reg [15:0] of_r;
    reg [2:0] age_r;
    wire [16:0] hi = {1'b0, det_r[15:0]} + {1'b0, det_r[31:16]};
    wire [15:0] dif = i_out_freq >= i_freq_ref ?
        i_out_freq - i_freq_ref : i_freq_ref - i_out_freq;
    wire agw = dif <= det_r[31:16];
    wire f2w = i_out_freq >= det_r[15:0] && {1'b0, i_out_freq} < hi;
    wire src4 = pc_r[6:4] == 3'h4;
    // Judge only once config has settled four cycles and frequency has held for one
    wire ok = age_r[2] && !i_wr && i_out_freq == of_r;
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            {sel_r, det_r, brk_r, typ_r, ud_r, pc_r} <= 192'h0;
            of_r <= 16'h0;
            age_r <= 3'h0;
        end else begin
            of_r <= i_out_freq;
            if (!age_r[2])
                age_r <= age_r + 3'h1;
            if (i_wr) begin
                age_r <= 3'h0;
                case (i_addr)
                    `FDRP_A_OUTSEL: sel_r <= i_wdata;
                    `FDRP_A_DET: det_r <= i_wdata;
                    `FDRP_A_BRAKE: brk_r <= i_wdata;
                    `FDRP_A_TYPE: typ_r <= i_wdata;
                    `FDRP_A_UPDN: ud_r <= i_wdata;
                    `FDRP_A_PCFG: pc_r <= i_wdata;
                    default: ;
                endcase
            end
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    property p_rd;
        !$past(i_rd) |-> o_rdata == 32'h0000_0000;
    endproperty
    a_rd: assert property (p_rd) else $error("rdata idle");
    property p_f1on;
        ok && sel_r[4:0] == 5'h04 && !typ_r[0] && i_out_freq > hi
        |=> o_first_relay;
    endproperty
    a_f1on: assert property (p_f1on) else $error("fdet1 on");
    property p_f1off;
        ok && sel_r[4:0] == 5'h04 && !typ_r[0] && i_out_freq < det_r[15:0]
        |=> !o_first_relay;
    endproperty
    a_f1off: assert property (p_f1off) else $error("fdet1 off");
    property p_f2;
        ok && sel_r[12:8] == 5'h05
        |=> o_second_relay == ($past(f2w) ^ typ_r[1]);
    endproperty
    a_f2: assert property (p_f2) else $error("fdet2");
    property p_agr;
        ok && sel_r[20:16] == 5'h03
        |=> o_photo_out == ($past(agw) ^ typ_r[8]);
    endproperty
    a_agr: assert property (p_agr) else $error("agree");
    property p_brk;
        ok && sel_r[4:0] == 5'h0E && !typ_r[0] && i_accel &&
        i_out_freq >= brk_r[15:0] |=> o_first_relay;
    endproperty
    a_brk: assert property (p_brk) else $error("brake");
    property p_fc;
        ok |=> o_use_freq_cmd == (src4 && pc_r[1:0] == 2'h0);
    endproperty
    a_fc: assert property (p_fc) else $error("freq cmd");
    property p_fb;
        ok |=> o_use_pid_fb ==
            (src4 && pc_r[1:0] == 2'h1 && pc_r[10:8] == 3'h3);
    endproperty
    a_fb: assert property (p_fb) else $error("pid fb");
    property p_se;
        ok |=> o_pulse_setting_error ==
            (pc_r[1:0] == 2'h1 && pc_r[10:8] != 3'h3);
    endproperty
    a_se: assert property (p_se) else $error("setting err");
    property p_udc;
        ok && ud_r[1:0] == 2'h1 && !i_run && $past(i_run)
        |-> ##[1:2] o_updn_ref == 16'h0000;
    endproperty
    a_udc: assert property (p_udc) else $error("updn clear");
    property p_udh;
        (ok && ud_r[1:0] == 2'h0 && !i_run)[*3] |=> $stable(o_updn_ref);
    endproperty
    a_udh: assert property (p_udh) else $error("updn hold");
    property p_udf;
        (ok && ud_r[1:0] == 2'h2 && !i_run && i_up && !i_down &&
        o_updn_ref != 16'hFFFF)[*2]
        |=> o_updn_ref == $past(o_updn_ref) + 16'h0001;
    endproperty
    a_udf: assert property (p_udf) else $error("updn free");
endmodule

bind fdrp_top fdrp_chk #(.WIN_CYC(WIN_CYC)) u_chk (
    .i_clk_sys, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_out_freq, .i_freq_ref, .i_accel, .i_run, .i_up, .i_down,
    .o_first_relay, .o_second_relay, .o_photo_out, .o_updn_ref,
    .o_use_freq_cmd, .o_use_pid_fb, .o_pulse_setting_error
);

// *** test/fdrp_psrc.sv ***
module fdrp_psrc (
    input wire i_clk_sys,
    input wire [7:0] i_half,
    output wire o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt = 8'h00;
    logic pin_r = 1'b0;
    assign o_pin = pin_r;
    // Half period zero: source silent, pin rests low
    always @(posedge i_clk_sys) begin
        if (i_half == 8'h00) begin
            pin_r <= 1'b0;
            cnt <= 8'h00;
        end else if (cnt + 8'h01 >= i_half) begin
            pin_r <= !pin_r;
            cnt <= 8'h00;
        end else
            cnt <= cnt + 8'h01;
    end
endmodule

// *** test/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic i_accel = 1'b0, i_decel = 1'b0, i_run = 1'b0, i_up = 1'b0;
    logic i_down = 1'b0, pin, r1, r2, ph, ufc, ufb, utg, serr, irq;
    logic [7:0] i_addr = 8'h00, half = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic [15:0] i_out_freq = 16'h0, i_freq_ref = 16'h0, o_updn_ref;
    logic signed [31:0] o_pulse_pct;
    int err_count = 0, checks = 0;
    always #4 i_clk_sys = !i_clk_sys;
    // Short window keeps the run brief; Hz readings scale with it
    fdrp_top #(.WIN_CYC(1000)) DUT (
        .i_clk_sys, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_out_freq, .i_freq_ref, .i_accel, .i_decel, .i_run, .i_up,
        .i_down, .i_pulse_train_input(pin), .o_first_relay(r1),
        .o_second_relay(r2), .o_photo_out(ph), .o_updn_ref,
        .o_pulse_pct, .o_use_freq_cmd(ufc), .o_use_pid_fb(ufb),
        .o_use_pid_tgt(utg), .o_pulse_setting_error(serr), .o_irq(irq)
    );
    fdrp_psrc u_src (.i_clk_sys, .i_half(half), .o_pin(pin));
    task automatic results;
        if (err_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        cyc(1);
        i_wr <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(logic [7:0] a, output logic [31:0] d);
        i_addr <= a;
        i_rd <= 1'b1;
        cyc(1);
        i_rd <= 1'b0;
        cyc(1);
        d = o_rdata;
    endtask
    task automatic rc(string n, logic [7:0] a, logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(n, e, d);
    endtask
    task automatic t_regs;
        rc("pscale", 8'h18, 32'h0000_2710);
        rc("pgb", 8'h1C, 32'h0000_03E8);
        wr(8'h24, 32'hFFFF_FFFF);
        rc("stat ro", 8'h24, 32'h0000_0000);
        rc("unmapped", 8'h3C, 32'h0000_0000);
    endtask
    task automatic t_det;
        logic [15:0] f [5] = '{16'h01F4, 16'h04B0, 16'h0514, 16'h044C,
            16'h0384};
        logic [4:0] e1 = 5'b01100, e2 = 5'b10111, e3 = 5'b11110;
        i_freq_ref <= 16'h044C;
        wr(8'h00, 32'h0003_0504);
        wr(8'h04, 32'h00C8_03E8);
        wr(8'h0C, 32'h0000_0002);
        foreach (f[i]) begin
            i_out_freq <= f[i];
            cyc(4);
            chk("relay1", {31'h0, e1[i]}, {31'h0, r1});
            chk("relay2", {31'h0, e2[i]}, {31'h0, r2});
            chk("photo", {31'h0, e3[i]}, {31'h0, ph});
        end
        wr(8'h0C, 32'h0000_0100);
        cyc(3);
        chk("photo nc", 32'h0, {31'h0, ph});
        chk("relay2 no", 32'h0, {31'h0, r2});
    endtask
    task automatic t_brk;
        logic [31:0] d;
        wr(8'h0C, 32'h0000_0000);
        wr(8'h08, 32'h012C_01F4);
        i_out_freq <= 16'h0190;
        i_accel <= 1'b1;
        wr(8'h00, 32'h0000_000E);
        cyc(3);
        chk("brk low", 32'h0, {31'h0, r1});
        i_out_freq <= 16'h01F4;
        cyc(4);
        chk("brk rel", 32'h1, {31'h0, r1});
        i_accel <= 1'b0;
        i_decel <= 1'b1;
        i_out_freq <= 16'h0190;
        cyc(4);
        chk("brk hold", 32'h1, {31'h0, r1});
        i_out_freq <= 16'h012C;
        cyc(4);
        chk("brk op", 32'h0, {31'h0, r1});
        i_decel <= 1'b0;
        rd(8'h30, d);
        chk("brk event", 32'h2, d & 32'h0000_0002);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(8'h34, 32'h0000_0002);
        cyc(2);
        chk("irq", 32'h1, {31'h0, irq});
        wr(8'h30, 32'h0000_0002);
        cyc(2);
        chk("irq clr", 32'h0, {31'h0, irq});
    endtask
    task automatic t_ud;
        wr(8'h10, 32'h0000_0002);
        i_up <= 1'b1;
        cyc(10);
        i_up <= 1'b0;
        cyc(3);
        chk("ud free", 32'h000A, {16'h0, o_updn_ref});
        wr(8'h10, 32'h0000_0000);
        i_run <= 1'b1;
        i_up <= 1'b1;
        cyc(5);
        i_up <= 1'b0;
        cyc(3);
        i_run <= 1'b0;
        i_down <= 1'b1;
        cyc(4);
        i_down <= 1'b0;
        cyc(2);
        chk("ud hold", 32'h000F, {16'h0, o_updn_ref});
        i_run <= 1'b1;
        cyc(3);
        chk("ud rerun", 32'h000F, {16'h0, o_updn_ref});
        wr(8'h10, 32'h0000_0001);
        cyc(4);
        i_run <= 1'b0;
        cyc(3);
        chk("ud clear", 32'h0000, {16'h0, o_updn_ref});
    endtask
    task automatic t_route;
        logic [31:0] c [6] = '{32'h0000_0340, 32'h0000_0341, 32'h0000_0342,
            32'h0000_0343, 32'h0000_0241, 32'h0000_0310};
        logic [3:0] e [6] = '{4'h8, 4'h4, 4'h2, 4'h0, 4'h1, 4'h0};
        foreach (c[i]) begin
            wr(8'h14, c[i]);
            cyc(5);
            chk("route", e[i], {ufc, ufb, utg, serr});
        end
    endtask
    task automatic wp(logic [31:0] e);
        logic [31:0] d;
        rd(8'h28, d);
        for (int i = 0; i < 10 && d !== e; i++) begin
            cyc(500);
            rd(8'h28, d);
        end
        chk("pfreq", e, d);
        if (d !== e)
            results;
    endtask
    task automatic t_pulse;
        logic [31:0] d;
        half <= 8'h0A;
        wp(32'h0000_1388);
        cyc(3);
        chk("pct", 32'h0000_01F4, o_pulse_pct);
        wr(8'h1C, 32'hFF9C_07D0);
        cyc(2100);
        chk("pct gb", 32'h0000_0384, o_pulse_pct);
        wr(8'h18, 32'h0000_1388);
        cyc(2100);
        chk("pct scale", 32'h0000_076C, o_pulse_pct);
        wr(8'h20, 32'h0000_0001);
        half <= 8'h14;
        cyc(2100);
        rd(8'h28, d);
        chk("filt", 32'h1, {31'h0, d > 32'h09C4 && d < 32'h1388});
    endtask
    initial begin
        cyc(8);
        i_nrst <= 1'b1;
        cyc(1);
        t_regs;
        t_det;
        t_brk;
        t_ud;
        t_route;
        t_pulse;
        results;
    end
endmodule
